// File: hdl/sgw_pkg.sv
// Purpose: Shared constants for the sensor gateway register map
// Assumes: Holding register numbers are used directly as word addresses
// Notes:   Set-value items are 32 bits, low word at the lower address
package sgw_pkg;
	localparam int          ADDR_W        = 20;
	localparam int          UNITS         = 15;
	localparam int          SEL_W         = 4;
	// Holding register word addresses
	localparam logic [19:0] A_EXT_WORD    = 20'h61b08;
	localparam logic [19:0] A_SELECT      = 20'h61e69;
	localparam logic [19:0] A_STATUS      = 20'h61e6b;
	localparam logic [19:0] A_UNIT_RESET  = 20'h61e73;
	localparam logic [19:0] A_FACTORY     = 20'h61e75;
	localparam logic [19:0] A_DECISION    = 20'h61e89;
	localparam logic [19:0] A_PLAIN       = 20'h61e8b;
	localparam logic [19:0] A_DERIVED     = 20'h61e8d;
	localparam logic [19:0] A_PROBE       = 20'h61e8f;
	localparam logic [19:0] A_LOW_TH      = 20'h61e91;
	localparam logic [19:0] A_HIGH_TH     = 20'h61e93;
	localparam logic [19:0] A_BAND        = 20'h61e99;
	localparam logic [19:0] A_POLARITY    = 20'h61e9d;
	localparam logic [19:0] A_OUT_LEVELS  = 20'h61ea1;
	localparam logic [19:0] A_IN_LEVELS   = 20'h61ea3;
	localparam logic [19:0] A_BANK_LOAD   = 20'h61ea5;
	localparam logic [19:0] A_ONE         = 20'h00001;
	// Coil numbers of the control word bits and coil write values
	localparam logic [15:0] COIL_FIRST    = 16'h00f1;
	localparam logic [15:0] COIL_LAST     = 16'h00ff;
	localparam logic [15:0] COIL_OFF      = 16'h0000;
	localparam logic [15:0] COIL_ON       = 16'hff00;
	// Value limits
	localparam logic [3:0]  SEL_LIMIT     = 4'he;
	localparam logic [3:0]  SEL_RESET     = 4'h0;
	localparam logic [31:0] BANK_MIN      = 32'h00000001;
	localparam logic [31:0] BANK_MAX      = 32'h00000003;
	localparam logic [31:0] LEVEL_MASK    = 32'h00000007;
	localparam logic [14:0] EXT_RESET     = 15'h0000;
	// Item access kinds
	typedef enum logic [1:0] {
		SGW_K_NONE = 2'h0,
		SGW_K_RO   = 2'h1,
		SGW_K_RW   = 2'h2,
		SGW_K_WO   = 2'h3
	} sgw_kind_e;
	// Controller state machine
	typedef enum logic [2:0] {
		SGW_ST_IDLE = 3'h1,
		SGW_ST_WAIT = 3'h2,
		SGW_ST_RESP = 3'h4
	} sgw_state_e;
endpackage

// File: hdl/sgw_input_drive.sv
// Purpose: Merge remote and physical external inputs of every controller
// Assumes: Physical inputs are asynchronous pins
// Notes:   Output is registered so glitches never reach the controllers
`timescale 1ns/1ps
module sgw_input_drive (
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        reset_n,
	input  wire logic        clk_en,
	// Sources
	input  wire logic [14:0] remote_in,
	input  wire logic [14:0] phys_in,
	// Drive to controllers
	output logic      [14:0] unit_in_drive
);
	logic [14:0] sync1_reg;
	logic [14:0] sync2_reg;
	logic [14:0] drive_reg;
	logic [14:0] sync1_next;
	logic [14:0] sync2_next;
	logic [14:0] drive_next;

	always_comb begin
		sync1_next = sync1_reg;
		sync2_next = sync2_reg;
		drive_next = drive_reg;
		if (clk_en) begin
			sync1_next = phys_in;
			sync2_next = sync1_reg;
			drive_next = remote_in | sync2_reg;
		end
	end

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			sync1_reg <= sgw_pkg::EXT_RESET;
			sync2_reg <= sgw_pkg::EXT_RESET;
			drive_reg <= sgw_pkg::EXT_RESET;
		end else begin
			sync1_reg <= sync1_next;
			sync2_reg <= sync2_next;
			drive_reg <= drive_next;
		end
	end

	assign unit_in_drive = drive_reg;
endmodule

// File: hdl/sgw_regmap.sv
// Purpose: Register map between the host protocol engine and the controller chain
// Assumes: Protocol framing is decoded upstream into word, coil and contact requests
// Notes:   Overview of the numbered behaviour follows
// Overview of operation
// - Coil value 0000 clears, FF00 sets input
// - Contact write 0 clears, 1 sets input
// - Control word bits hold one input per unit
// - Unit input is remote OR physical level
// - Selection 0 master, 1..14 slave units
// - Selection 15+ or absent unit returns error
// - Set-value accesses go to selected unit
// - Low half at lower address, high above
// - Status error reads zero or error code
// - Initialization restores defaults; zero is refused
// - Measured values are signed, range limited
// - Derived read falls back to decision value
// - Level registers keep only bits 0..2
// - Bank load accepts only banks 1..3
// - Control word reads back remote setting
// - Coil and word share one stored bit
`timescale 1ns/1ps
module sgw_regmap (
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        reset_n,
	input  wire logic        clk_en,
	// Holding register requests
	input  wire logic        req_valid,
	output logic             req_ready,
	input  wire logic        req_write,
	input  wire logic [19:0] req_addr,
	input  wire logic [15:0] req_wdata,
	output logic             rsp_valid,
	output logic      [15:0] rsp_rdata,
	output logic             rsp_error,
	// Coil and contact writes
	input  wire logic        coil_valid,
	input  wire logic [15:0] coil_addr,
	input  wire logic [15:0] coil_value,
	input  wire logic        contact_valid,
	input  wire logic [3:0]  contact_bit,
	input  wire logic        contact_value,
	output logic             coil_done,
	output logic             coil_error,
	// Controller chain
	input  wire logic [14:0] unit_present,
	input  wire logic        derived_value_configured,
	output logic      [3:0]  unit_sel,
	output logic             unit_req,
	output logic             unit_write,
	output logic      [19:0] unit_item,
	output logic      [31:0] unit_wdata,
	input  wire logic        unit_ack,
	input  wire logic [31:0] unit_rdata,
	// External inputs
	input  wire logic [14:0] phys_in,
	output logic      [14:0] unit_in_drive
);
	sgw_pkg::sgw_state_e state_reg, state_next;
	logic [3:0]  sel_reg, sel_next;
	logic [14:0] ext_reg, ext_next;
	logic [15:0] lo_reg, lo_next;
	logic [15:0] hi_reg, hi_next;
	logic [15:0] rdata_reg, rdata_next;
	logic        err_reg, err_next;
	logic        ureq_reg, ureq_next;
	logic        uwr_reg, uwr_next;
	logic [19:0] item_reg, item_next;
	logic [31:0] uwd_reg, uwd_next;
	logic        cdone_reg, cdone_next;
	logic        cerr_reg, cerr_next;
	logic        mask_reg, mask_next;
	logic [31:0] wval;
	logic [19:0] base;
	logic [15:0] coil_idx;
	sgw_pkg::sgw_kind_e lo_kind, hi_kind;

	// Access kind of a 32-bit item by its low word address
	function automatic sgw_pkg::sgw_kind_e item_kind(input logic [19:0] a);
		if (a == sgw_pkg::A_STATUS || a == sgw_pkg::A_DECISION || a == sgw_pkg::A_PLAIN)
			item_kind = sgw_pkg::SGW_K_RO;
		else if (a == sgw_pkg::A_DERIVED || a == sgw_pkg::A_PROBE)
			item_kind = sgw_pkg::SGW_K_RO;
		else if (a == sgw_pkg::A_OUT_LEVELS || a == sgw_pkg::A_IN_LEVELS)
			item_kind = sgw_pkg::SGW_K_RO;
		else if (a == sgw_pkg::A_LOW_TH || a == sgw_pkg::A_HIGH_TH)
			item_kind = sgw_pkg::SGW_K_RW;
		else if (a == sgw_pkg::A_BAND || a == sgw_pkg::A_POLARITY)
			item_kind = sgw_pkg::SGW_K_RW;
		else if (a == sgw_pkg::A_UNIT_RESET || a == sgw_pkg::A_FACTORY || a == sgw_pkg::A_BANK_LOAD)
			item_kind = sgw_pkg::SGW_K_WO;
		else
			item_kind = sgw_pkg::SGW_K_NONE;
	endfunction

	assign base     = req_addr - sgw_pkg::A_ONE;
	assign lo_kind  = item_kind(req_addr);
	assign hi_kind  = item_kind(base);
	assign wval     = {req_wdata, lo_reg};
	assign coil_idx = coil_addr - sgw_pkg::COIL_FIRST;

	// Host request, controller access and the shared control word
	always_comb begin
		state_next = state_reg;
		sel_next   = sel_reg;
		ext_next   = ext_reg;
		lo_next    = lo_reg;
		hi_next    = hi_reg;
		rdata_next = rdata_reg;
		err_next   = err_reg;
		ureq_next  = ureq_reg;
		uwr_next   = uwr_reg;
		item_next  = item_reg;
		uwd_next   = uwd_reg;
		cdone_next = 1'b0;
		cerr_next  = cerr_reg;
		mask_next  = mask_reg;
		if (clk_en) begin
			case (state_reg)
				sgw_pkg::SGW_ST_IDLE: begin
					if (req_valid) begin
						state_next = sgw_pkg::SGW_ST_RESP;
						err_next   = 1'b0;
						rdata_next = 16'h0000;
						if (req_addr == sgw_pkg::A_EXT_WORD) begin
							if (req_write)
								ext_next = req_wdata[14:0];
							else
								rdata_next = {1'b0, ext_reg};
						end else if (req_addr == sgw_pkg::A_SELECT) begin
							if (!req_write)
								rdata_next = {12'h000, sel_reg};
							else if (req_wdata > {12'h000, sgw_pkg::SEL_LIMIT})
								err_next = 1'b1;
							else if (!unit_present[req_wdata[3:0]])
								err_next = 1'b1;
							else
								sel_next = req_wdata[3:0];
						end else if (!unit_present[sel_reg] &&
							(lo_kind != sgw_pkg::SGW_K_NONE || hi_kind != sgw_pkg::SGW_K_NONE)) begin
							err_next = 1'b1;
						end else if (!req_write && (lo_kind == sgw_pkg::SGW_K_RO || lo_kind == sgw_pkg::SGW_K_RW)) begin
							// Low word read fetches the whole item; high half waits in hi_reg, zeroed for level items
							state_next = sgw_pkg::SGW_ST_WAIT;
							ureq_next  = 1'b1;
							uwr_next   = 1'b0;
							item_next  = req_addr;
							mask_next  = (req_addr == sgw_pkg::A_OUT_LEVELS) || (req_addr == sgw_pkg::A_IN_LEVELS);
							if (req_addr == sgw_pkg::A_DERIVED && !derived_value_configured)
								item_next = sgw_pkg::A_DECISION;
						end else if (!req_write && (hi_kind == sgw_pkg::SGW_K_RO || hi_kind == sgw_pkg::SGW_K_RW)) begin
							rdata_next = hi_reg;
						end else if (req_write && (lo_kind == sgw_pkg::SGW_K_WO || lo_kind == sgw_pkg::SGW_K_RW)) begin
							lo_next = req_wdata;
						end else if (req_write && (hi_kind == sgw_pkg::SGW_K_WO || hi_kind == sgw_pkg::SGW_K_RW)) begin
							if (base == sgw_pkg::A_FACTORY && wval == 32'h00000000)
								err_next = 1'b1;
							else if (base == sgw_pkg::A_BANK_LOAD &&
								(wval < sgw_pkg::BANK_MIN || wval > sgw_pkg::BANK_MAX))
								err_next = 1'b1;
							else begin
								state_next = sgw_pkg::SGW_ST_WAIT;
								ureq_next  = 1'b1;
								uwr_next   = 1'b1;
								item_next  = base;
								uwd_next   = wval;
							end
						end else begin
							// Unmapped, reserved or wrong-direction access
							err_next = 1'b1;
						end
					end
				end
				sgw_pkg::SGW_ST_WAIT: begin
					// No timeout: a selected unit that is present must answer
					if (unit_ack) begin
						ureq_next  = 1'b0;
						state_next = sgw_pkg::SGW_ST_RESP;
						if (!uwr_reg) begin
							if (mask_reg) begin
								rdata_next = unit_rdata[15:0] & sgw_pkg::LEVEL_MASK[15:0];
								hi_next    = 16'h0000;
							end else begin
								rdata_next = unit_rdata[15:0];
								hi_next    = unit_rdata[31:16];
							end
						end
					end
				end
				sgw_pkg::SGW_ST_RESP: begin
					state_next = sgw_pkg::SGW_ST_IDLE;
				end
				default: begin
					state_next = sgw_pkg::SGW_ST_IDLE;
				end
			endcase
			// Bit access wins over a same-cycle word write, being the later intent
			if (coil_valid) begin
				cdone_next = 1'b1;
				cerr_next  = 1'b0;
				if (coil_addr < sgw_pkg::COIL_FIRST || coil_addr > sgw_pkg::COIL_LAST)
					cerr_next = 1'b1;
				else if (coil_value == sgw_pkg::COIL_OFF)
					ext_next[coil_idx[3:0]] = 1'b0;
				else if (coil_value == sgw_pkg::COIL_ON)
					ext_next[coil_idx[3:0]] = 1'b1;
				else
					cerr_next = 1'b1;
			end else if (contact_valid) begin
				cdone_next = 1'b1;
				cerr_next  = (contact_bit == 4'hf);
				if (contact_bit != 4'hf)
					ext_next[contact_bit] = contact_value;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			state_reg <= sgw_pkg::SGW_ST_IDLE;
			sel_reg   <= sgw_pkg::SEL_RESET;
			ext_reg   <= sgw_pkg::EXT_RESET;
			lo_reg    <= 16'h0000;
			hi_reg    <= 16'h0000;
			rdata_reg <= 16'h0000;
			err_reg   <= 1'b0;
			ureq_reg  <= 1'b0;
			uwr_reg   <= 1'b0;
			item_reg  <= 20'h00000;
			uwd_reg   <= 32'h00000000;
			cdone_reg <= 1'b0;
			cerr_reg  <= 1'b0;
			mask_reg  <= 1'b0;
		end else begin
			state_reg <= state_next;
			sel_reg   <= sel_next;
			ext_reg   <= ext_next;
			lo_reg    <= lo_next;
			hi_reg    <= hi_next;
			rdata_reg <= rdata_next;
			err_reg   <= err_next;
			ureq_reg  <= ureq_next;
			uwr_reg   <= uwr_next;
			item_reg  <= item_next;
			uwd_reg   <= uwd_next;
			cdone_reg <= cdone_next;
			cerr_reg  <= cerr_next;
			mask_reg  <= mask_next;
		end
	end

	assign req_ready  = (state_reg == sgw_pkg::SGW_ST_IDLE);
	assign rsp_valid  = (state_reg == sgw_pkg::SGW_ST_RESP);
	assign rsp_rdata  = rdata_reg;
	assign rsp_error  = err_reg;
	assign coil_done  = cdone_reg;
	assign coil_error = cerr_reg;
	assign unit_sel   = sel_reg;
	assign unit_req   = ureq_reg;
	assign unit_write = uwr_reg;
	assign unit_item  = item_reg;
	assign unit_wdata = uwd_reg;

	sgw_input_drive u_drive (
		.mclk          (mclk),
		.reset_n       (reset_n),
		.clk_en        (clk_en),
		.remote_in     (ext_reg),
		.phys_in       (phys_in),
		.unit_in_drive (unit_in_drive)
	);
endmodule

// File: dv/sgw_regmap_sva.sv
// Purpose: Port checks of the sensor gateway register map
// Assumes: One clock domain, clk_en held high by the bench
// Notes:   Helper regs keep the last taken word request
`timescale 1ns/1ps
module sgw_regmap_sva (
	// Clock and reset
	input wire logic        mclk,
	input wire logic        reset_n,
	input wire logic        clk_en,
	// Host word group
	input wire logic        req_valid,
	input wire logic        req_ready,
	input wire logic        req_write,
	input wire logic [19:0] req_addr,
	input wire logic [15:0] req_wdata,
	input wire logic        rsp_valid,
	input wire logic [15:0] rsp_rdata,
	input wire logic        rsp_error,
	// Coil group
	input wire logic        coil_valid,
	input wire logic [15:0] coil_addr,
	input wire logic [15:0] coil_value,
	input wire logic        coil_done,
	input wire logic        coil_error,
	// Controller chain and inputs
	input wire logic [14:0] unit_present,
	input wire logic        derived_value_configured,
	input wire logic [3:0]  unit_sel,
	input wire logic        unit_req,
	input wire logic [19:0] unit_item,
	input wire logic [31:0] unit_wdata,
	input wire logic        unit_ack,
	input wire logic [14:0] phys_in,
	input wire logic [14:0] unit_in_drive
);
	logic [19:0] aq;
	logic [15:0] dq;
	logic        wq;
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!reset_n);
	// Requests never overlap, so one capture is enough
	always_ff @(posedge mclk) begin
		if (clk_en && req_valid && req_ready) begin
			aq <= req_addr;
			dq <= req_wdata;
			wq <= req_write;
		end
	end
	AST_SEL_TAKE: assert property (rsp_valid && !rsp_error && wq && aq == sgw_pkg::A_SELECT
		|-> unit_sel == dq[3:0] && dq < 16'h000f) else $error("select not taken");
	AST_SEL_KEEP: assert property (rsp_valid && rsp_error |-> $stable(unit_sel)) else $error("select moved");
	AST_FETCH_PRESENT: assert property ($rose(unit_req) |-> unit_present[unit_sel]) else $error("absent unit");
	AST_REQ_HOLD: assert property (unit_req && !unit_ack
		|=> unit_req && $stable(unit_item) && $stable(unit_wdata)) else $error("request dropped");
	AST_DERIVED: assert property ($rose(unit_req) && !derived_value_configured
		|-> unit_item != sgw_pkg::A_DERIVED) else $error("derived fetched");
	AST_LEVEL_MASK: assert property (rsp_valid && !rsp_error && !wq
		&& (aq == sgw_pkg::A_OUT_LEVELS || aq == sgw_pkg::A_IN_LEVELS)
		|-> rsp_rdata[15:3] == 13'h0000) else $error("level upper bits");
	AST_COIL_BAD: assert property (clk_en && coil_valid && coil_value != sgw_pkg::COIL_ON
		&& coil_value != sgw_pkg::COIL_OFF |=> coil_done && coil_error) else $error("bad coil taken");
	AST_COIL_ON: assert property (clk_en && coil_valid && coil_value == sgw_pkg::COIL_ON
		&& coil_addr >= sgw_pkg::COIL_FIRST && coil_addr <= sgw_pkg::COIL_LAST
		|=> ##1 unit_in_drive[$past(coil_addr[3:0], 2) - 4'h1]) else $error("coil not driven");
	AST_INPUT_OR: assert property ($past(reset_n, 3) && $past(reset_n, 2) && $past(reset_n)
		&& phys_in == $past(phys_in) && phys_in == $past(phys_in, 2) && phys_in == $past(phys_in, 3)
		|-> (unit_in_drive & phys_in) == phys_in) else $error("physical input lost");
endmodule
bind sgw_regmap sgw_regmap_sva i_sva (.mclk, .reset_n, .clk_en, .req_valid, .req_ready, .req_write,
	.req_addr, .req_wdata, .rsp_valid, .rsp_rdata, .rsp_error, .coil_valid, .coil_addr, .coil_value,
	.coil_done, .coil_error, .unit_present, .derived_value_configured, .unit_sel, .unit_req, .unit_item,
	.unit_wdata, .unit_ack, .phys_in, .unit_in_drive);

// File: dv/sgw_unit_model.sv
// Purpose: Behavioural controller chain behind the register map
// Assumes: Item store indexed by unit and low address byte
// Notes:   Answers alternate fast and slow; data toggles off the ack
`timescale 1ns/1ps
module sgw_unit_model (
	// Clock
	input wire logic        mclk,
	// Request
	input wire logic        unit_req,
	input wire logic        unit_write,
	input wire logic [3:0]  unit_sel,
	input wire logic [19:0] unit_item,
	input wire logic [31:0] unit_wdata,
	// Answer
	output logic            unit_ack,
	output logic     [31:0] unit_rdata
);
	logic [31:0] mem [0:4095];
	logic [2:0]  cnt = 3'h0;
	logic        slow = 1'b0;
	logic        done = 1'b0;
	initial begin
		for (int i = 0; i < 4096; i++) mem[i] = 32'hfffffffe;
		unit_ack = 1'b0;
		unit_rdata = 32'ha5a5a5a5;
	end
	always @(posedge mclk) begin
		unit_ack <= 1'b0;
		unit_rdata <= ~unit_rdata;
		if (!unit_req) begin
			cnt <= 3'h0;
			done <= 1'b0;
		end else if (!done && cnt == (slow ? 3'h4 : 3'h0)) begin
			unit_ack <= 1'b1;
			done <= 1'b1;
			slow <= !slow;
			if (unit_write) mem[{unit_sel, unit_item[7:0]}] <= unit_wdata;
			else unit_rdata <= mem[{unit_sel, unit_item[7:0]}];
		end else cnt <= cnt + 3'h1;
	end
endmodule

// File: dv/testbench.sv
// Purpose: Self-checking bench of the sensor gateway register map
// Assumes: Unit model answers item traffic
// Notes:   Word and coil tasks wait out each answer before returning
`timescale 1ns/1ps
module testbench;
	logic mclk = 1'b0, reset_n = 1'b0, clk_en = 1'b1, req_valid = 1'b0, req_write = 1'b0;
	logic [19:0] req_addr = 20'h00000;
	logic [15:0] req_wdata = 16'h0000, coil_addr = 16'h0000, coil_value = 16'h0000;
	logic coil_valid = 1'b0, contact_valid = 1'b0, contact_value = 1'b0, derived_value_configured = 1'b1;
	logic [3:0] contact_bit = 4'h0;
	logic [14:0] unit_present = 15'h4007, phys_in = 15'h0000;
	logic req_ready, rsp_valid, rsp_error, coil_done, coil_error, unit_req, unit_write, unit_ack;
	logic [15:0] rsp_rdata;
	logic [3:0] unit_sel;
	logic [19:0] unit_item;
	logic [31:0] unit_wdata, unit_rdata;
	logic [14:0] unit_in_drive;
	int n_fail = 0, cmp_count = 0;
	always #50 mclk = ~mclk;
	sgw_regmap i_dut (.mclk(mclk), .reset_n(reset_n), .clk_en(clk_en), .req_valid(req_valid),
		.req_ready(req_ready), .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
		.rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_error(rsp_error), .coil_valid(coil_valid),
		.coil_addr(coil_addr), .coil_value(coil_value), .contact_valid(contact_valid),
		.contact_bit(contact_bit), .contact_value(contact_value), .coil_done(coil_done),
		.coil_error(coil_error), .unit_present(unit_present), .derived_value_configured(derived_value_configured),
		.unit_sel(unit_sel), .unit_req(unit_req), .unit_write(unit_write), .unit_item(unit_item),
		.unit_wdata(unit_wdata), .unit_ack(unit_ack), .unit_rdata(unit_rdata), .phys_in(phys_in),
		.unit_in_drive(unit_in_drive));
	sgw_unit_model i_model (.mclk(mclk), .unit_req(unit_req), .unit_write(unit_write),
		.unit_sel(unit_sel), .unit_item(unit_item), .unit_wdata(unit_wdata), .unit_ack(unit_ack),
		.unit_rdata(unit_rdata));
	task automatic report_and_stop();
		if (n_fail == 0 && cmp_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic acc(input logic w, input logic [19:0] a, input logic [15:0] d, input logic e);
		while (req_ready !== 1'b1) @(posedge mclk) #1;
		{req_valid, req_write, req_addr, req_wdata} = {1'b1, w, a, d};
		@(posedge mclk) #1;
		req_valid = 1'b0;
		for (int k = 0; k < 40 && rsp_valid !== 1'b1; k++) @(posedge mclk) #1;
		chk("rsp_valid", rsp_valid, 1);
		chk("rsp_error", rsp_error, e);
		if (!w && !e) chk("rsp_rdata", rsp_rdata, d);
		@(posedge mclk) #1;
	endtask
	task automatic ct(input logic c, input logic [15:0] a, input logic [15:0] v, input logic e);
		{coil_valid, contact_valid, coil_addr, coil_value} = {c, !c, a, v};
		{contact_bit, contact_value} = {a[3:0], v[0]};
		@(posedge mclk) #1;
		{coil_valid, contact_valid} = 2'b00;
		chk("coil_done", coil_done, 1);
		chk("coil_error", coil_error, e);
		@(posedge mclk) #1;
	endtask
	task automatic t_inputs();
		acc(0, sgw_pkg::A_EXT_WORD, 16'h0000, 0);
		ct(1, sgw_pkg::COIL_FIRST, sgw_pkg::COIL_ON, 0);
		ct(0, 16'h000e, 16'h0001, 0);
		acc(0, sgw_pkg::A_EXT_WORD, 16'h4001, 0);
		ct(0, 16'h000e, 16'h0000, 0);
		ct(1, sgw_pkg::COIL_FIRST, 16'h1234, 1);
		ct(1, 16'h0100, sgw_pkg::COIL_ON, 1);
		ct(0, 16'h000f, 16'h0001, 1);
		acc(0, sgw_pkg::A_EXT_WORD, 16'h0001, 0);
		acc(1, sgw_pkg::A_EXT_WORD, 16'hffff, 0);
		ct(1, 16'h00f2, sgw_pkg::COIL_OFF, 0);
		acc(0, sgw_pkg::A_EXT_WORD, 16'h7ffd, 0);
		acc(1, sgw_pkg::A_EXT_WORD, 16'h0000, 0);
		phys_in = 15'h0100;
		repeat (5) @(posedge mclk) #1;
		acc(0, sgw_pkg::A_EXT_WORD, 16'h0000, 0);
		chk("unit_in_drive", unit_in_drive, 15'h0100);
		acc(1, sgw_pkg::A_EXT_WORD, 16'h0001, 0);
		repeat (2) @(posedge mclk) #1;
		chk("unit_in_drive", unit_in_drive, 15'h0101);
		phys_in = 15'h0000;
	endtask
	task automatic t_select();
		chk("unit_sel", unit_sel, 0);
		acc(1, sgw_pkg::A_SELECT, 16'h000e, 0);
		acc(1, sgw_pkg::A_SELECT, 16'h000f, 1);
		acc(1, sgw_pkg::A_SELECT, 16'h0005, 1);
		acc(0, sgw_pkg::A_SELECT, 16'h000e, 0);
		acc(1, sgw_pkg::A_SELECT, 16'h0002, 0);
		chk("unit_sel", unit_sel, 2);
		unit_present = 15'h4003;
		acc(0, sgw_pkg::A_LOW_TH, 16'h0000, 1);
		unit_present = 15'h4007;
	endtask
	task automatic t_items();
		acc(1, sgw_pkg::A_LOW_TH, 16'h7b81, 0);
		acc(1, sgw_pkg::A_LOW_TH + sgw_pkg::A_ONE, 16'hffe1, 0);
		chk("low_threshold", i_model.mem[12'h291], 32'hffe17b81);
		acc(0, sgw_pkg::A_LOW_TH, 16'h7b81, 0);
		acc(0, sgw_pkg::A_LOW_TH + sgw_pkg::A_ONE, 16'hffe1, 0);
		{i_model.mem[12'h289], derived_value_configured} = {32'h001e847f, 1'b0};
		acc(0, sgw_pkg::A_DERIVED, 16'h847f, 0);
		acc(0, sgw_pkg::A_DERIVED + sgw_pkg::A_ONE, 16'h001e, 0);
		{i_model.mem[12'h28d], derived_value_configured} = {32'h00000005, 1'b1};
		acc(0, sgw_pkg::A_DERIVED, 16'h0005, 0);
		acc(0, sgw_pkg::A_OUT_LEVELS, 16'h0006, 0);
		acc(0, sgw_pkg::A_OUT_LEVELS + sgw_pkg::A_ONE, 16'h0000, 0);
		acc(0, sgw_pkg::A_IN_LEVELS, 16'h0006, 0);
		i_model.mem[12'h26b] = 32'h00000003;
		acc(0, sgw_pkg::A_STATUS, 16'h0003, 0);
		acc(1, sgw_pkg::A_STATUS, 16'h0001, 1);
		acc(1, sgw_pkg::A_SELECT, 16'h0001, 0);
		acc(0, sgw_pkg::A_LOW_TH, 16'hfffe, 0);
		acc(1, sgw_pkg::A_SELECT, 16'h0002, 0);
	endtask
	task automatic t_refuse();
		acc(1, sgw_pkg::A_FACTORY, 16'h0000, 0);
		acc(1, sgw_pkg::A_FACTORY + sgw_pkg::A_ONE, 16'h0000, 1);
		acc(1, sgw_pkg::A_BANK_LOAD, 16'h0004, 0);
		acc(1, sgw_pkg::A_BANK_LOAD + sgw_pkg::A_ONE, 16'h0000, 1);
		acc(1, sgw_pkg::A_BANK_LOAD, 16'h0003, 0);
		acc(1, sgw_pkg::A_BANK_LOAD + sgw_pkg::A_ONE, 16'h0000, 0);
		chk("bank_restore_cmd", i_model.mem[12'h2a5], 32'h00000003);
		acc(1, sgw_pkg::A_FACTORY, 16'h0001, 0);
		acc(1, sgw_pkg::A_FACTORY + sgw_pkg::A_ONE, 16'h0000, 0);
		chk("factory_default_cmd", i_model.mem[12'h275], 32'h00000001);
		acc(0, sgw_pkg::A_BANK_LOAD, 16'h0000, 1);
		acc(0, 20'h61e6f, 16'h0000, 1);
		acc(1, sgw_pkg::A_UNIT_RESET, 16'h0000, 0);
		acc(1, sgw_pkg::A_UNIT_RESET + sgw_pkg::A_ONE, 16'h0000, 0);
		chk("unit_reset_cmd", i_model.mem[12'h273], 32'h00000000);
		acc(1, sgw_pkg::A_BAND, 16'h0010, 0);
		acc(1, sgw_pkg::A_BAND + sgw_pkg::A_ONE, 16'h0000, 0);
		acc(0, sgw_pkg::A_BAND, 16'h0010, 0);
		acc(0, sgw_pkg::A_BAND + sgw_pkg::A_ONE, 16'h0000, 0);
	endtask
	task automatic t_reset();
		acc(1, sgw_pkg::A_EXT_WORD, 16'h0003, 0);
		reset_n = 1'b0;
		repeat (12) @(posedge mclk) #1;
		reset_n = 1'b1;
		chk("unit_sel", unit_sel, 0);
		chk("req_ready", req_ready, 1);
		acc(0, sgw_pkg::A_EXT_WORD, 16'h0000, 0);
		repeat (3) @(posedge mclk) #1;
		chk("unit_in_drive", unit_in_drive, 15'h0000);
	endtask
	initial begin
		#2000000;
		n_fail++;
		report_and_stop();
	end
	initial begin
		repeat (12) @(posedge mclk);
		#1 reset_n = 1'b1;
		t_inputs();
		t_select();
		t_items();
		t_refuse();
		t_reset();
		report_and_stop();
	end
endmodule
